//--- logic/gshp_map.svh
`ifndef GSHP_MAP_SVH
`define GSHP_MAP_SVH
// timing
`define GSHP_CLK_HZ    40000000
`define GSHP_BAUD_TOP  9600
`define GSHP_OVS       16
`define GSHP_DIV_BASE  (`GSHP_CLK_HZ/(`GSHP_BAUD_TOP*`GSHP_OVS))
`define GSHP_TALK_S    5
`define GSHP_TALK_CYC  (`GSHP_TALK_S*`GSHP_CLK_HZ)
// register byte offsets
`define GSHP_CONFIG    8'h00
`define GSHP_STATUS    8'h04
`define GSHP_TXDATA    8'h08
`define GSHP_RXDATA    8'h0c
`define GSHP_CTRL      8'h10
`define GSHP_READ0     8'h14
`define GSHP_READ1     8'h18
`define GSHP_READ2     8'h1c
// config field positions
`define GSHP_CFG_FDCD  8
`define GSHP_CFG_FCTS  7
`define GSHP_CFG_MODE  6
`define GSHP_CFG_LEN8  5
`define GSHP_CFG_EVEN  4
`define GSHP_CFG_STOP1 3
// reset values
`define GSHP_CFG_RST   9'h1ff
`define GSHP_CTRL_RST  1'b1
`define GSHP_READ_RST  32'h20202020
// characters
`define GSHP_CHR_CR    8'h0d
`define GSHP_CHR_LF    8'h0a
`define GSHP_CHR_COMMA 8'h2c
`endif

//--- logic/gshp_pkg.sv
package gshp_pkg;
  typedef logic [7:0] gshp_byte_t;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP}
    gshp_tx_e;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP}
    gshp_rx_e;
endpackage

//--- logic/gshp_strm_if.sv
`timescale 1ns/1ps
interface gshp_strm_if #(parameter int W = 8);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

//--- logic/gshp_fifo.sv
`timescale 1ns/1ps
module gshp_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // fill and drain sides
  gshp_strm_if.snk wr,
  gshp_strm_if.src rd
);
  localparam int AW = $clog2(DEPTH);
  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad
      $error("fifo depth must be a power of two, at least 2");
    end
  endgenerate

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0]   cnt;
  logic          do_wr;
  logic          do_rd;

  // honest full and empty
  assign wr.ready = (cnt != (AW+1)'(DEPTH));
  assign rd.valid = (cnt != '0);
  assign rd.data  = mem[rp];
  assign do_wr    = wr.valid & wr.ready;
  assign do_rd    = rd.valid & rd.ready;

  // storage
  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem[wp] <= wr.data;
    end
  end

  // pointers and fill count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp  <= '0;
      rp  <= '0;
      cnt <= '0;
    end else begin
      if (do_wr) wp <= wp + 1'b1;
      if (do_rd) rp <= rp + 1'b1;
      cnt <= cnt + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end
endmodule // gshp_fifo

//--- logic/gshp_baud.sv
`timescale 1ns/1ps
module gshp_baud #(
  parameter int unsigned DIV_BASE = 260
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // rate: 0 fastest, each step halves
  input  wire logic [2:0] rate_sel,
  output logic            tick
);
  generate
    if (DIV_BASE < 9 || (DIV_BASE << 7) > 65536) begin : g_bad
      $error("baud divider base out of range");
    end
  endgenerate

  logic [15:0] cnt;
  logic [15:0] lim;

  // integer divider for the oversampling tick
  assign lim = 16'((DIV_BASE << rate_sel) - 1);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt  <= '0;
      tick <= 1'b0;
    end else begin
      tick <= (cnt == lim);
      cnt  <= (cnt >= lim) ? 16'h0000 : cnt + 16'h0001;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_tick_gap;
    tick |=> !tick [*8];
  endproperty
  a_tick_gap: assert property (p_tick_gap)
    else $error("oversample ticks too close");
  c_tick: cover property (tick ##1 !tick [*8]);
endmodule // gshp_baud

//--- logic/gshp_port.sv
// Functional notes
// - baud from three switches, 9600 down 75
// - factory: 9600 8N1, modem inputs forced
// - switches latched once after power-up
// - framing switches set length, parity, stops
// - mode switch: off talk-only, on command
// - talk-only: three readings, commas, every 5s
// - no secondary module: first reading only
// - send byte only with CTS and DSR
// - force switch makes CTS and DSR true
// - drop characters seen without carrier detect
// - RTS up on terminator, down after reply
`timescale 1ns/1ps
`include "gshp_map.svh"
module gshp_port import gshp_pkg::*; #(
  parameter int unsigned TALK_CYCLES = `GSHP_TALK_CYC,
  parameter int unsigned DIV_BASE    = `GSHP_DIV_BASE,
  parameter int          FIFO_DEPTH  = 8
) (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RST_N,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // serial line
  input  wire logic        RXD,
  output logic             TXD,
  // modem lines, 1 = true
  input  wire logic        CTS,
  input  wire logic        DSR,
  input  wire logic        DCD,
  output logic             RTS,
  // internal switches, 1 = on
  input  wire logic        MODE_SELECT_SWITCH,
  input  wire logic [2:0]  FRAME_SWITCH,
  input  wire logic        BAUD_SELECT_BIT2,
  input  wire logic        BAUD_SELECT_BIT1,
  input  wire logic        BAUD_SELECT_BIT0,
  input  wire logic        FORCE_CTS_DSR_SWITCH,
  input  wire logic        FORCE_DCD_SWITCH
);
  generate
    if (TALK_CYCLES < 64 || TALK_CYCLES >= (1 << 28)) begin : g_bad
      $error("talk period out of range");
    end
  endgenerate

  logic [1:0]  rst_sync;
  logic        rst_n;
  logic [12:0] pin_m;
  logic [12:0] pin_s;
  logic        rxd_s;
  logic        cts_s;
  logic        dsr_s;
  logic        dcd_s;
  logic [8:0]  cfg;
  logic [1:0]  cfg_cnt;
  logic        cfg_done;
  logic        talk_mode;
  logic        len8;
  logic        cts_ok;
  logic        dcd_ok;
  logic        tick;
  logic [2:0]  rate_sel;

  // reset release through two flops
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) rst_sync <= 2'h0;
    else        rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  // pin synchronisers
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      pin_m <= 13'h0000;
      pin_s <= 13'h0000;
    end else begin
      pin_m <= {RXD, CTS, DSR, DCD, FORCE_DCD_SWITCH,
                FORCE_CTS_DSR_SWITCH, MODE_SELECT_SWITCH,
                FRAME_SWITCH, BAUD_SELECT_BIT2,
                BAUD_SELECT_BIT1, BAUD_SELECT_BIT0};
      pin_s <= pin_m;
    end
  end
  assign rxd_s = pin_s[12];
  assign cts_s = pin_s[11];
  assign dsr_s = pin_s[10];
  assign dcd_s = pin_s[9];

  // switches caught once, after the synchroniser has filled
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      cfg     <= `GSHP_CFG_RST;
      cfg_cnt <= 2'h0;
    end else if (!cfg_done) begin
      cfg_cnt <= cfg_cnt + 2'h1;
      if (cfg_cnt == 2'h2) cfg <= pin_s[8:0];
    end
  end
  assign cfg_done  = (cfg_cnt == 2'h3);
  assign talk_mode = !cfg[`GSHP_CFG_MODE];
  assign len8      = cfg[`GSHP_CFG_LEN8];
  assign cts_ok    = cfg[`GSHP_CFG_FCTS] | (cts_s & dsr_s);
  assign dcd_ok    = cfg[`GSHP_CFG_FDCD] | dcd_s;
  assign rate_sel  = ~cfg[2:0];

  gshp_baud #(.DIV_BASE(DIV_BASE)) u_baud (
    .clk      (CLK),
    .rst_n    (rst_n),
    .rate_sel (rate_sel),
    .tick     (tick)
  );

  // registers and bus decode
  gshp_strm_if #(.W(8)) push ();
  gshp_strm_if #(.W(8)) pop ();
  logic        ctrl_sec;
  logic [31:0] rdg [3];
  logic        rx_valid;
  logic        rx_ovr;
  logic [7:0]  rx_data;
  logic        rx_put;
  logic [7:0]  rx_byte;
  logic        acc;
  logic        tx_wr;
  logic        rx_rd;
  logic        hit;
  logic        talk_busy;
  logic [7:0]  talk_chr;

  assign acc   = PSEL & PENABLE;
  assign tx_wr = acc & PWRITE & (PADDR == `GSHP_TXDATA) & !talk_mode;
  assign rx_rd = acc & !PWRITE & PREADY & (PADDR == `GSHP_RXDATA);
  assign hit   = (PADDR[7:5] == 3'h0) & (PADDR[1:0] == 2'h0);
  // a full fifo stalls the bus write
  assign PREADY  = !(tx_wr & !push.ready);
  assign PSLVERR = acc & !hit;

  // read data captured in the setup cycle
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      PRDATA <= 32'h00000000;
    end else if (PSEL & !PENABLE) begin
      case (PADDR)
        `GSHP_CONFIG: PRDATA <= {23'h000000, cfg};
        `GSHP_STATUS: PRDATA <= {26'h0000000, talk_mode, RTS,
                                 pop.valid, !push.ready, rx_ovr, rx_valid};
        `GSHP_RXDATA: PRDATA <= {24'h000000, rx_data};
        `GSHP_CTRL:   PRDATA <= {31'h00000000, ctrl_sec};
        `GSHP_READ0:  PRDATA <= rdg[0];
        `GSHP_READ1:  PRDATA <= rdg[1];
        `GSHP_READ2:  PRDATA <= rdg[2];
        default:      PRDATA <= 32'h00000000;
      endcase
    end
  end

  // writable registers
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_sec <= `GSHP_CTRL_RST;
      rdg[0]   <= `GSHP_READ_RST;
      rdg[1]   <= `GSHP_READ_RST;
      rdg[2]   <= `GSHP_READ_RST;
    end else if (acc & PWRITE) begin
      if (PADDR == `GSHP_CTRL)  ctrl_sec <= PWDATA[0];
      if (PADDR == `GSHP_READ0) rdg[0]   <= PWDATA;
      if (PADDR == `GSHP_READ1) rdg[1]   <= PWDATA;
      if (PADDR == `GSHP_READ2) rdg[2]   <= PWDATA;
    end
  end

  // received byte holding, new byte wins over a read
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      rx_valid <= 1'b0;
      rx_ovr   <= 1'b0;
      rx_data  <= 8'h00;
    end else if (rx_put) begin
      rx_data  <= rx_byte;
      rx_valid <= 1'b1;
      rx_ovr   <= rx_valid & !rx_rd;
    end else if (rx_rd) begin
      rx_valid <= 1'b0;
      rx_ovr   <= 1'b0;
    end
  end

  // fifo source: talk engine or software
  assign push.valid = talk_mode ? talk_busy : tx_wr;
  assign push.data  = talk_mode ? talk_chr : PWDATA[7:0];

  gshp_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk   (CLK),
    .rst_n (rst_n),
    .wr    (push),
    .rd    (pop)
  );

  // talk-only message engine
  logic [27:0] talk_cnt;
  logic [3:0]  talk_idx;
  logic [31:0] talk_word;
  logic [1:0]  talk_sel;

  always_comb begin
    talk_sel  = 2'h0;
    if (talk_idx >= 4'h5) talk_sel = 2'h1;
    if (talk_idx >= 4'ha) talk_sel = 2'h2;
    talk_word = rdg[talk_sel];
    case (talk_idx)
      4'h4, 4'h9: talk_chr = `GSHP_CHR_COMMA;
      4'he:       talk_chr = `GSHP_CHR_CR;
      4'hf:       talk_chr = `GSHP_CHR_LF;
      4'h0, 4'h5, 4'ha: talk_chr = talk_word[31:24];
      4'h1, 4'h6, 4'hb: talk_chr = talk_word[23:16];
      4'h2, 4'h7, 4'hc: talk_chr = talk_word[15:8];
      default:    talk_chr = talk_word[7:0];
    endcase
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      talk_cnt  <= 28'h0000000;
      talk_idx  <= 4'h0;
      talk_busy <= 1'b0;
    end else if (!talk_mode || !cfg_done) begin
      talk_cnt  <= 28'h0000000;
      talk_busy <= 1'b0;
    end else begin
      talk_cnt <= (talk_cnt == 28'(TALK_CYCLES - 1)) ? 28'h0000000
                                                     : talk_cnt + 28'h1;
      if (talk_cnt == 28'(TALK_CYCLES - 1) && !talk_busy) begin
        talk_busy <= 1'b1;
        talk_idx  <= 4'h0;
      end else if (talk_busy && push.ready) begin
        if (talk_idx == 4'hf)
          talk_busy <= 1'b0;
        else if (talk_idx == 4'h3 && !ctrl_sec)
          talk_idx <= 4'he;
        else
          talk_idx <= talk_idx + 4'h1;
      end
    end
  end

  // transmitter
  gshp_tx_e    tx_st;
  logic [3:0]  tx_sub;
  logic [2:0]  tx_bit;
  logic [7:0]  tx_sh;
  logic [7:0]  tx_cur;
  logic        tx_stop2;
  logic        tx_end;

  assign pop.ready = (tx_st == TX_IDLE) & cts_ok & cfg_done;
  assign tx_end    = (tx_st == TX_STOP) & tick & (tx_sub == 4'hf) &
                     (tx_stop2 | cfg[`GSHP_CFG_STOP1]);

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      tx_st    <= TX_IDLE;
      tx_sub   <= 4'h0;
      tx_bit   <= 3'h0;
      tx_sh    <= 8'h00;
      tx_cur   <= 8'h00;
      tx_stop2 <= 1'b0;
      TXD      <= 1'b1;
    end else begin
      if (tick) tx_sub <= tx_sub + 4'h1;
      case (tx_st)
        TX_IDLE: begin
          TXD <= 1'b1;
          if (pop.valid & pop.ready) begin
            tx_sh  <= pop.data;
            tx_cur <= pop.data;
            tx_st  <= TX_START;
            tx_sub <= 4'h0;
            TXD    <= 1'b0;
          end
        end
        TX_START: if (tick && tx_sub == 4'hf) begin
          tx_st  <= TX_DATA;
          tx_bit <= 3'h0;
          TXD    <= tx_sh[0];
        end
        TX_DATA: if (tick && tx_sub == 4'hf) begin
          tx_sh  <= {1'b0, tx_sh[7:1]};
          tx_bit <= tx_bit + 3'h1;
          TXD    <= tx_sh[1];
          if (tx_bit == (len8 ? 3'h7 : 3'h6)) begin
            tx_st    <= len8 ? TX_STOP : TX_PAR;
            tx_stop2 <= 1'b0;
            TXD      <= len8 ? 1'b1 : (^tx_cur[6:0] ^
                                       !cfg[`GSHP_CFG_EVEN]);
          end
        end
        TX_PAR: if (tick && tx_sub == 4'hf) begin
          tx_st <= TX_STOP;
          TXD   <= 1'b1;
        end
        TX_STOP: if (tick && tx_sub == 4'hf) begin
          tx_stop2 <= 1'b1;
          if (tx_end) tx_st <= TX_IDLE;
        end
        default: tx_st <= TX_IDLE;
      endcase
    end
  end

  // receiver, 16x oversampled, mid-bit samples
  gshp_rx_e    rx_st;
  logic [3:0]  rx_sub;
  logic [2:0]  rx_bit;
  logic [7:0]  rx_sh;
  logic        rx_bad;

  assign rx_byte = len8 ? rx_sh : {1'b0, rx_sh[7:1]};

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      rx_st  <= RX_IDLE;
      rx_sub <= 4'h0;
      rx_bit <= 3'h0;
      rx_sh  <= 8'h00;
      rx_bad <= 1'b0;
      rx_put <= 1'b0;
    end else begin
      rx_put <= 1'b0;
      if (tick) rx_sub <= rx_sub + 4'h1;
      if (rx_st != RX_IDLE && !dcd_ok) rx_bad <= 1'b1;
      case (rx_st)
        RX_IDLE: if (cfg_done && !rxd_s) begin
          rx_st  <= RX_START;
          rx_sub <= 4'h0;
          rx_bad <= !dcd_ok;
        end
        RX_START: if (tick && rx_sub == 4'h7) begin
          rx_sub <= 4'h0;
          rx_bit <= 3'h0;
          rx_st  <= rxd_s ? RX_IDLE : RX_DATA;
        end
        RX_DATA: if (tick && rx_sub == 4'hf) begin
          rx_sh  <= {rxd_s, rx_sh[7:1]};
          rx_bit <= rx_bit + 3'h1;
          if (rx_bit == (len8 ? 3'h7 : 3'h6))
            rx_st <= len8 ? RX_STOP : RX_PAR;
        end
        RX_PAR: if (tick && rx_sub == 4'hf) begin
          rx_st <= RX_STOP;
          if ((^rx_sh[7:1] ^ rxd_s) != !cfg[`GSHP_CFG_EVEN])
            rx_bad <= 1'b1;
        end
        RX_STOP: if (tick && rx_sub == 4'hf) begin
          rx_st  <= RX_IDLE;
          rx_put <= rxd_s & !rx_bad & dcd_ok;
        end
        default: rx_st <= RX_IDLE;
      endcase
    end
  end

  // request-to-send: terminator in raises, reply terminator out drops
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n)
      RTS <= 1'b0;
    else if (rx_put && rx_byte == `GSHP_CHR_CR)
      RTS <= 1'b1;
    else if (tx_end && tx_cur == `GSHP_CHR_CR)
      RTS <= 1'b0;
  end

  default clocking @(posedge CLK); endclocking
  default disable iff (!rst_n);

  property p_rts_up;
    rx_put && rx_byte == `GSHP_CHR_CR |=> RTS;
  endproperty
  a_rts_up: assert property (p_rts_up)
    else $error("rts not raised on terminator");
  property p_rts_down;
    tx_end && tx_cur == `GSHP_CHR_CR && !rx_put |=> !RTS;
  endproperty
  a_rts_down: assert property (p_rts_down)
    else $error("rts not dropped after reply");
  property p_cfg_hold;
    cfg_done |=> $stable(cfg) && cfg_done;
  endproperty
  a_cfg_hold: assert property (p_cfg_hold)
    else $error("switch settings changed while running");
  property p_cts_gate;
    tx_st == TX_IDLE ##1 tx_st == TX_START |-> $past(cts_ok);
  endproperty
  a_cts_gate: assert property (p_cts_gate)
    else $error("byte started without cts and dsr");
  property p_force;
    cfg[`GSHP_CFG_FCTS] && tx_st == TX_IDLE && pop.valid && cfg_done
      |=> tx_st == TX_START;
  endproperty
  a_force: assert property (p_force)
    else $error("forced handshake did not send");
  // carrier lost inside a character marks it bad and keeps it out
  property p_dcd_drop;
    rx_st != RX_IDLE && !dcd_ok |=> rx_bad && !rx_put;
  endproperty
  a_dcd_drop: assert property (p_dcd_drop)
    else $error("character kept without carrier");
  property p_talk_quiet;
    !talk_mode |-> !talk_busy;
  endproperty
  a_talk_quiet: assert property (p_talk_quiet)
    else $error("talk engine active in command mode");
  property p_sec_absent;
    talk_busy && !ctrl_sec |-> talk_idx < 4'h4 || talk_idx > 4'hd;
  endproperty
  a_sec_absent: assert property (p_sec_absent)
    else $error("secondary readings sent while absent");
  property p_start_bit;
    tx_st == TX_IDLE ##1 tx_st == TX_START |-> !TXD [*2];
  endproperty
  a_start_bit: assert property (p_start_bit)
    else $error("start bit not low");

  c_rx_term: cover property (rx_put && rx_byte == `GSHP_CHR_CR);
  c_tx_term: cover property (tx_end && tx_cur == `GSHP_CHR_CR);
  c_talk: cover property (talk_busy && talk_idx == 4'hf && push.ready);
  c_stall: cover property (tx_wr && !PREADY);
endmodule // gshp_port

//--- testbench/gshp_host_model.sv
`timescale 1ns/1ps
module gshp_host_model (
  // clock
  input  wire logic       clk,
  // device side of the line
  input  wire logic       dev_txd,
  input  wire logic       dev_rts,
  // host outputs, 1 = true
  output logic            host_txd,
  output logic            cts,
  output logic            dsr,
  output logic            dcd,
  // character taken from the device
  output logic            got,
  output logic      [7:0] got_byte
);
  int bit_cyc = 144;
  int stops   = 1;

  // line idles at mark, modem lines start false
  initial begin
    host_txd = 1'b1;
    cts      = 1'b0;
    dsr      = 1'b0;
    dcd      = 1'b0;
    got      = 1'b0;
    got_byte = 8'h00;
  end

  // bit time in clocks and stop count of the frame
  task automatic setup(input int bc, input int st);
    bit_cyc = bc;
    stops   = st;
  endtask

  // carrier and ready lines change only when the bench asks
  task automatic modem(input logic c, input logic d, input logic k);
    cts <= c;
    dsr <= d;
    dcd <= k;
  endtask

  // start bit, eight bits lsb first, then the stop bits
  task automatic send(input logic [7:0] b);
    while (dev_rts === 1'b1) @(posedge clk);
    host_txd <= 1'b0;
    repeat (bit_cyc) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      host_txd <= b[i];
      repeat (bit_cyc) @(posedge clk);
    end
    host_txd <= 1'b1;
    repeat (bit_cyc * stops) @(posedge clk);
  endtask

  // sample device characters mid-bit, flag only with a high stop
  always begin
    @(posedge clk);
    if (dev_txd === 1'b0) begin
      repeat (bit_cyc / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
        repeat (bit_cyc) @(posedge clk);
        got_byte[i] <= dev_txd;
      end
      repeat (bit_cyc) @(posedge clk);
      got <= dev_txd;
      @(posedge clk);
      got <= 1'b0;
    end
  end
endmodule // gshp_host_model

//--- testbench/gauge_serial_host_port_tb.sv
`timescale 1ns/1ps
`include "gshp_map.svh"
module gauge_serial_host_port_tb;
  localparam int BIT   = 144;
  localparam int TALK  = 24000;
  localparam int LIMIT = 100000;
  logic        CLK, RST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic [7:0]  PADDR;
  logic [31:0] PWDATA, PRDATA;
  logic        RXD, TXD, CTS, DSR, DCD, RTS, MODE, FCTS, FDCD, GOT;
  logic [2:0]  FRAME, BAUD;
  logic [7:0]  GOT_B;
  logic [32:0] rd_q[$];
  logic [7:0]  tx_q[$];
  logic [31:0] rdg[3];
  logic [31:0] seed = 32'hfe070692;
  int          mismatches = 0;
  int          checks = 0;
  int          cyc = 0;
  int          t1, t2;

  gshp_port #(.TALK_CYCLES(TALK), .DIV_BASE(9), .FIFO_DEPTH(8)) dut (
    .CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .RXD(RXD), .TXD(TXD),
    .CTS(CTS), .DSR(DSR), .DCD(DCD), .RTS(RTS),
    .MODE_SELECT_SWITCH(MODE), .FRAME_SWITCH(FRAME),
    .BAUD_SELECT_BIT2(BAUD[2]), .BAUD_SELECT_BIT1(BAUD[1]),
    .BAUD_SELECT_BIT0(BAUD[0]), .FORCE_CTS_DSR_SWITCH(FCTS),
    .FORCE_DCD_SWITCH(FDCD));
  gshp_host_model host (
    .clk(CLK), .dev_txd(TXD), .dev_rts(RTS), .host_txd(RXD), .cts(CTS),
    .dsr(DSR), .dcd(DCD), .got(GOT), .got_byte(GOT_B));

  // clock
  initial begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
  endfunction
  // seven data bits with even parity on top
  function automatic logic [7:0] frame7(input logic [7:0] d);
    return {^d[6:0], d[6:0]};
  endfunction

  task automatic check(input logic [32:0] seen, input logic [32:0] want);
    checks++;
    if (seen !== want) begin
      mismatches++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic tally_and_finish;
    if (mismatches == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // one apb transfer, pready seen at a rising edge, then one idle cycle
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    PSEL    <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE  <= w;
    PADDR   <= a;
    PWDATA  <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLK);
    end while (PREADY !== 1'b1);
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLK);
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] want);
    rd_q.push_back(want);
    apb(1'b0, a, 32'h0);
  endtask

  // power cycle with a new switch setting
  task automatic power_up(input logic m, input logic [2:0] f,
                          input logic [2:0] b, input logic fc);
    RST_N <= 1'b0;
    MODE  <= m;
    FRAME <= f;
    BAUD  <= b;
    FCTS  <= fc;
    FDCD  <= fc;
    repeat (5) @(posedge CLK);
    check({31'h0, TXD, RTS}, 33'h2);
    RST_N <= 1'b1;
    repeat (10) @(posedge CLK);
  endtask

  // wait until every noted character came; t0 marks the first one
  task automatic drain(output int t0);
    int n;
    n = tx_q.size();
    while (tx_q.size() == n) @(posedge CLK);
    t0 = cyc;
    while (tx_q.size() != 0) @(posedge CLK);
  endtask

  // compare finished reads and received characters with their notes
  always @(negedge CLK) begin
    if (PSEL && PENABLE && !PWRITE && PREADY === 1'b1) begin
      if (rd_q.size() == 0) check(33'h1, 33'h0);
      else check({PSLVERR, PRDATA}, rd_q.pop_front());
    end
  end
  always @(posedge CLK) begin
    if (GOT === 1'b1) begin
      if (tx_q.size() == 0) check(33'h1, 33'h0);
      else check({25'h0, GOT_B}, {25'h0, tx_q.pop_front()});
    end
  end

  // cycle count and hang limit
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      mismatches++;
      tally_and_finish();
    end
  end

  initial begin
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA} <= '0;
    // factory setting, host lines false, switches moved after power-up
    power_up(1'b1, 3'h7, 3'h7, 1'b1);
    {MODE, FRAME, BAUD, FCTS, FDCD} <= 9'h0;
    rd(`GSHP_CONFIG, 33'h1ff);
    rd(`GSHP_CTRL, 33'h1);
    rd(`GSHP_READ0, {1'b0, `GSHP_READ_RST});
    rd(8'h20, 33'h100000000);
    rd(8'h06, 33'h100000000);
    for (int i = 0; i < 10; i++) begin
      seed = lfsr(seed);
      tx_q.push_back(seed[7:0]);
      apb(1'b1, `GSHP_TXDATA, {24'h0, seed[7:0]});
      if (i == 8) rd(`GSHP_STATUS, 33'h0c);
    end
    drain(t1);
    host.send(8'h41);
    host.send(`GSHP_CHR_CR);
    repeat (3) @(posedge CLK);
    check({32'h0, RTS}, 33'h1);
    rd(`GSHP_STATUS, 33'h13);
    rd(`GSHP_RXDATA, {25'h0, `GSHP_CHR_CR});
    rd(`GSHP_STATUS, 33'h10);
    tx_q.push_back(`GSHP_CHR_CR);
    apb(1'b1, `GSHP_TXDATA, {24'h0, `GSHP_CHR_CR});
    drain(t1);
    repeat (BIT) @(posedge CLK);
    check({32'h0, RTS}, 33'h0);
    // talk-only broadcast, host writes are dropped
    power_up(1'b0, 3'h7, 3'h7, 1'b1);
    rd(`GSHP_STATUS, 33'h20);
    apb(1'b1, `GSHP_TXDATA, 32'h55);
    for (int r = 0; r < 3; r++) begin
      seed = lfsr(seed);
      for (int c = 0; c < 4; c++) rdg[r][8*c +: 8] = 8'h30 + seed[3*c +: 3];
      apb(1'b1, 8'(`GSHP_READ0 + 4 * r), rdg[r]);
      for (int c = 3; c >= 0; c--) tx_q.push_back(rdg[r][8*c +: 8]);
      tx_q.push_back(r < 2 ? `GSHP_CHR_COMMA : `GSHP_CHR_CR);
    end
    tx_q.push_back(`GSHP_CHR_LF);
    drain(t1);
    apb(1'b1, `GSHP_CTRL, 32'h0);
    for (int c = 3; c >= 0; c--) tx_q.push_back(rdg[0][8*c +: 8]);
    tx_q.push_back(`GSHP_CHR_CR);
    tx_q.push_back(`GSHP_CHR_LF);
    drain(t2);
    check({32'h0, t2 - t1 > TALK - 160 && t2 - t1 < TALK + 160}, 33'h1);
    // 2400 baud, seven bits even parity, two stops, nothing forced
    power_up(1'b1, 3'h2, 3'h5, 1'b0);
    host.setup(BIT * 4, 2);
    rd(`GSHP_CONFIG, 33'h055);
    host.send(frame7(8'h41));
    rd(`GSHP_STATUS, 33'h0);
    host.modem(1'b0, 1'b0, 1'b1);
    host.send(frame7(8'h43));
    rd(`GSHP_RXDATA, 33'h43);
    host.modem(1'b1, 1'b0, 1'b1);
    apb(1'b1, `GSHP_TXDATA, 32'h31);
    repeat (2000) @(posedge CLK);
    rd(`GSHP_STATUS, 33'h08);
    tx_q.push_back(frame7(8'h31));
    host.modem(1'b1, 1'b1, 1'b1);
    drain(t1);
    tally_and_finish();
  end
endmodule // gauge_serial_host_port_tb
